// ===== itm_contacts.sv
// Purpose: far-side contacts driving the seven input terminals
// Assumes: levels requested by the bench, 1 = contact closed
// Notes: glitch mask flips pins for short spikes, bounce not modelled
`timescale 1ns/1ps

module itm_contacts (
  // clock
  input wire logic mclk,
  // requested levels
  input wire logic [6:0] want,
  input wire logic [6:0] glitch,
  // terminal pins
  output logic [6:0] term_in
);
  // ==========================================================
  // contact levels
  initial term_in = 7'h00;
  // pins move off the design's sampling phase like real switches
  always @(posedge mclk)
    term_in <= #3 want ^ glitch;
endmodule

// ===== itm_map.svh
// Purpose: offsets, codes, reset values and timing counts of the mapper
// Assumes: 50 MHz mclk, byte addresses on a plain register port
// Notes: definitions only
`ifndef ITM_MAP_SVH
`define ITM_MAP_SVH

// ==========================================================
// register byte offsets
`define ITM_OFS_SEL0 8'h00
`define ITM_SEL_STRIDE 8'h04
`define ITM_OFS_SHUTOFF 8'h1C
`define ITM_OFS_REMOTE 8'h20
`define ITM_OFS_SOC 8'h24
`define ITM_OFS_OPMODE 8'h28
`define ITM_OFS_STATUS 8'h2C
`define ITM_OFS_TERM 8'h30

// ==========================================================
// function codes
`define ITM_CODE_W 16
`define ITM_FN_LOW 16'h0000
`define ITM_FN_MID 16'h0001
`define ITM_FN_HIGH 16'h0002
`define ITM_FN_SECOND 16'h0003
`define ITM_FN_ANALOG 16'h0004
`define ITM_FN_JOG 16'h0005
`define ITM_FN_THERMAL 16'h0007
`define ITM_FN_SPEED_EXT 16'h0008
`define ITM_FN_RUN_EN 16'h000A
`define ITM_FN_INTERLOCK 16'h000C
`define ITM_FN_PID 16'h000E
`define ITM_FN_BRAKE 16'h000F
`define ITM_FN_PANEL_EXT 16'h0010
`define ITM_FN_CTRL_METHOD 16'h0012
`define ITM_FN_SHUTOFF 16'h0018
`define ITM_FN_SELF_HOLD 16'h0019
`define ITM_FN_FWD 16'h003C
`define ITM_FN_REV 16'h003D
`define ITM_FN_RESET 16'h003E
`define ITM_FN_PANEL_NET 16'h0041
`define ITM_FN_EXT_NET 16'h0042
`define ITM_FN_CMD_SRC 16'h0043
`define ITM_FN_NONE 16'h270F

// ==========================================================
// terminal positions holding forward / reverse start
`define ITM_TERM_FWD 0
`define ITM_TERM_REV 1

// ==========================================================
// reset values
`define ITM_RST_SEL0 `ITM_FN_FWD
`define ITM_RST_SEL1 `ITM_FN_REV
`define ITM_RST_SEL2 `ITM_FN_LOW
`define ITM_RST_SEL3 `ITM_FN_MID
`define ITM_RST_SEL4 `ITM_FN_HIGH
`define ITM_RST_SEL5 `ITM_FN_SHUTOFF
`define ITM_RST_SEL6 `ITM_FN_RESET
`define ITM_RST_SHUTOFF 16'h0000

// ==========================================================
// mode settings
`define ITM_SHUT_NO 16'h0000
`define ITM_SHUT_NC 16'h0002
`define ITM_SHUT_MIX 16'h0004
`define ITM_SOC_ON 16'h0001
`define ITM_OPMODE_INTERLOCK 16'h0007

// ==========================================================
// response times
`define ITM_CLK_NS 20
`define ITM_RESP_FAST_MS 2
`define ITM_RESP_SLOW_MS 20
`define ITM_RESP_FAST_CYC (`ITM_RESP_FAST_MS * 1000000 / `ITM_CLK_NS)
`define ITM_RESP_SLOW_CYC (`ITM_RESP_SLOW_MS * 1000000 / `ITM_CLK_NS)
`define ITM_FAST_FILT_CYC (`ITM_RESP_FAST_CYC / 2)
`define ITM_SLOW_FILT_CYC (`ITM_RESP_SLOW_CYC / 2)

`endif

// ===== itm_mapper.sv
// Purpose: map seven input terminals onto internal drive commands
// Assumes: terminal pins asynchronous, comm shutoff and drive_running
//          come from logic on mclk
// Notes: Functional notes below
//
// Functional notes
// - each terminal selector holds a code; 24 is shutoff, 9999 none
// - codes 0,1,2 are speeds; with remote mode 1 or 2 clear/decel/accel
// - code 3 is second function; stop-on-contact turns 0 and 3 into sel
// - code 8 is fourth speed bit, giving fifteen speeds with the other three
// - code 7 thermal relay input asserts when the contact opens
// - codes 16,65,66,67 select external, panel, network, command source
// - codes 60 and 61 only on forward and reverse start terminals
// - codes 15,10,12,14 brake done, run enable, interlock, PID valid
// - one code on several terminals drives the OR of them
// - speed priority is jog, then multi-speed, then PID valid
// - unassigned run enable or interlock in mode 7 taken by shutoff
// - control-method switchover change waits until the drive stops
// - V/F request while running applies only second function meanwhile
// - analog select asserted makes the voltage speed input ignored
// - run enable and shutoff respond within 2 ms, others within 20 ms
// - shutoff while running cuts output at once, motor coasts
// - shutoff active blocks any start command
// - logic 0 enables when both sources off; 2 when both on
// - logic 4 enables when terminal on and communication off
// - reset defaults 60, 61, 0, 1, 2, 24, 62
// - terminal shutoff cuts output in every operation mode
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "itm_map.svh"

module itm_mapper #(
  parameter int NUM_TERM = 7,
  parameter int FAST_FILT_CYC = `ITM_FAST_FILT_CYC,
  parameter int SLOW_FILT_CYC = `ITM_SLOW_FILT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // terminals and sources
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic comm_shutoff_in,
  input wire logic drive_running,
  // internal commands
  output itm_pkg::itm_speed_s speed_cmd,
  output itm_pkg::itm_remote_s remote_cmd,
  output itm_pkg::itm_ctrl_s ctrl_cmd,
  output logic output_cut,
  output logic start_inhibit,
  output logic voltage_input_ignore
);

  localparam int CW = `ITM_CODE_W;
  localparam int FW = $clog2(SLOW_FILT_CYC + 1);
  localparam logic [CW-1:0] RST_SEL [7] = '{`ITM_RST_SEL0, `ITM_RST_SEL1,
    `ITM_RST_SEL2, `ITM_RST_SEL3, `ITM_RST_SEL4, `ITM_RST_SEL5,
    `ITM_RST_SEL6};

  logic [NUM_TERM-1:0][CW-1:0] sel;
  logic [CW-1:0] shutoff_input_logic_select;
  logic [CW-1:0] remote_function_select;
  logic [CW-1:0] stop_on_contact_select;
  logic [CW-1:0] operation_mode_selection;
  logic [NUM_TERM-1:0] term_s1;
  logic [NUM_TERM-1:0] term_s2;
  logic [NUM_TERM-1:0] term_s3;
  logic [NUM_TERM-1:0] term_f;
  logic [NUM_TERM-1:0] term_fast;
  logic vf_request;

  // ==========================================================
  // helpers
  function automatic logic code_hit(input logic [NUM_TERM-1:0][CW-1:0] s,
    input logic [NUM_TERM-1:0] v, input logic [CW-1:0] c);
    logic r;
    r = 1'b0;
    // same code on many terminals
    // OR of inputs
    for (int i = 0; i < NUM_TERM; i++)
    begin
      r = r | (v[i] & (s[i] == c));
    end
    return r;
  endfunction

  function automatic logic code_ok(input int term, input logic [CW-1:0] c);
    logic r;
    r = 1'b0;
    unique case (c)
      `ITM_FN_LOW, `ITM_FN_MID, `ITM_FN_HIGH, `ITM_FN_SECOND,
      `ITM_FN_ANALOG, `ITM_FN_JOG, `ITM_FN_THERMAL, `ITM_FN_SPEED_EXT,
      `ITM_FN_RUN_EN, `ITM_FN_INTERLOCK, `ITM_FN_PID, `ITM_FN_BRAKE,
      `ITM_FN_PANEL_EXT, `ITM_FN_CTRL_METHOD, `ITM_FN_SHUTOFF,
      `ITM_FN_SELF_HOLD, `ITM_FN_RESET, `ITM_FN_PANEL_NET,
      `ITM_FN_EXT_NET, `ITM_FN_CMD_SRC, `ITM_FN_NONE:
        r = 1'b1;
      // start commands tied to their own terminals
      // placement check
      `ITM_FN_FWD:
        r = (term == `ITM_TERM_FWD);
      `ITM_FN_REV:
        r = (term == `ITM_TERM_REV);
      default:
        r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // terminal selectors
  // per-terminal code
  generate
    for (genvar g = 0; g < NUM_TERM; g++)
    begin : g_sel
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          sel[g] <= RST_SEL[g];
        else if (clk_en && bus_wr && bus_addr ==
                 8'(`ITM_OFS_SEL0 + g * `ITM_SEL_STRIDE))
        begin
          if (code_ok(g, bus_wdata[CW-1:0]))
            sel[g] <= bus_wdata[CW-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // mode settings
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      shutoff_input_logic_select <= `ITM_RST_SHUTOFF;
      remote_function_select <= '0;
      stop_on_contact_select <= '0;
      operation_mode_selection <= '0;
    end
    else if (clk_en && bus_wr)
    begin
      unique case (bus_addr)
        `ITM_OFS_SHUTOFF:
        begin
          // only the three defined contact logics are kept
          if (bus_wdata[CW-1:0] == `ITM_SHUT_NO ||
              bus_wdata[CW-1:0] == `ITM_SHUT_NC ||
              bus_wdata[CW-1:0] == `ITM_SHUT_MIX)
            shutoff_input_logic_select <= bus_wdata[CW-1:0];
        end
        `ITM_OFS_REMOTE:
          remote_function_select <= bus_wdata[CW-1:0];
        `ITM_OFS_SOC:
          stop_on_contact_select <= bus_wdata[CW-1:0];
        `ITM_OFS_OPMODE:
          operation_mode_selection <= bus_wdata[CW-1:0];
        default:
          ;
      endcase
    end
  end

  // ==========================================================
  // terminal synchronisers and response filters
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      term_s1 <= '0;
      term_s2 <= '0;
      term_s3 <= '0;
    end
    else if (clk_en)
    begin
      term_s1 <= term_in;
      term_s2 <= term_s1;
      term_s3 <= term_s2;
    end
  end

  generate
    for (genvar g = 0; g < NUM_TERM; g++)
    begin : g_filt
      logic [FW-1:0] cnt;
      logic [FW-1:0] lim;
      // fast terminals get the short filter
      // response limits
      assign term_fast[g] = (sel[g] == `ITM_FN_RUN_EN) ||
                            (sel[g] == `ITM_FN_SHUTOFF);
      assign lim = term_fast[g] ? FW'(FAST_FILT_CYC) : FW'(SLOW_FILT_CYC);
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          cnt <= '0;
          term_f[g] <= 1'b0;
        end
        else if (clk_en)
        begin
          // glitches shorter than the filter never reach a command
          if (term_s2[g] != term_s3[g] || term_s3[g] == term_f[g])
            cnt <= '0;
          else if (cnt >= lim - FW'(1))
          begin
            cnt <= '0;
            term_f[g] <= term_s3[g];
          end
          else
            cnt <= cnt + FW'(1);
        end
      end
    end
  endgenerate

  // ==========================================================
  // raw function decode
  logic f_low, f_mid, f_high, f_second, f_analog, f_jog, f_ext, f_pid;
  logic f_run_en, f_interlock, f_shut_t, f_vf, f_thermal;
  logic remote_on, soc_on, shut_enable;

  assign f_low = code_hit(sel, term_f, `ITM_FN_LOW);
  assign f_mid = code_hit(sel, term_f, `ITM_FN_MID);
  assign f_high = code_hit(sel, term_f, `ITM_FN_HIGH);
  assign f_second = code_hit(sel, term_f, `ITM_FN_SECOND);
  assign f_analog = code_hit(sel, term_f, `ITM_FN_ANALOG);
  assign f_jog = code_hit(sel, term_f, `ITM_FN_JOG);
  assign f_ext = code_hit(sel, term_f, `ITM_FN_SPEED_EXT);
  assign f_pid = code_hit(sel, term_f, `ITM_FN_PID);
  assign f_run_en = code_hit(sel, term_f, `ITM_FN_RUN_EN);
  assign f_interlock = code_hit(sel, term_f, `ITM_FN_INTERLOCK);
  assign f_shut_t = code_hit(sel, term_f, `ITM_FN_SHUTOFF);
  assign f_vf = code_hit(sel, term_f, `ITM_FN_CTRL_METHOD);
  // contact open reads as a low terminal
  // thermal asserts on open
  assign f_thermal = code_hit(sel, ~term_f, `ITM_FN_THERMAL);

  assign remote_on = (remote_function_select != '0);
  assign soc_on = (stop_on_contact_select == `ITM_SOC_ON);

  // contact logic of terminal and communication sources
  always_comb
  begin
    unique case (shutoff_input_logic_select)
      `ITM_SHUT_NC:
        shut_enable = f_shut_t & comm_shutoff_in;
      `ITM_SHUT_MIX:
        shut_enable = f_shut_t & ~comm_shutoff_in;
      default:
        shut_enable = ~f_shut_t & ~comm_shutoff_in;
    endcase
  end

  // ==========================================================
  // control method switchover
  // held until stopped
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      vf_request <= 1'b0;
    else if (clk_en && !drive_running)
      vf_request <= f_vf;
  end

  // ==========================================================
  // command outputs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      speed_cmd <= '0;
      remote_cmd <= '0;
      voltage_input_ignore <= 1'b0;
    end
    else if (clk_en)
    begin
      // jog first, then multi-speed, then PID
      speed_cmd.jog <= f_jog;
      // speed meaning only in mode 0
      speed_cmd.low <= ~f_jog & ~remote_on & ~soc_on & f_low;
      speed_cmd.mid <= ~f_jog & ~remote_on & f_mid;
      speed_cmd.high <= ~f_jog & ~remote_on & f_high;
      speed_cmd.ext <= ~f_jog & f_ext;
      speed_cmd.pid_valid <= f_pid & ~f_jog & ~f_ext &
        ~(~remote_on & ((f_low & ~soc_on) | f_mid | f_high));
      remote_cmd.clear <= remote_on & ~soc_on & f_low;
      remote_cmd.decel <= remote_on & f_mid;
      remote_cmd.accel <= remote_on & f_high;
      voltage_input_ignore <= f_analog;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_cmd <= '0;
    else if (clk_en)
    begin
      ctrl_cmd.fwd_start <= code_hit(sel, term_f, `ITM_FN_FWD) & shut_enable;
      ctrl_cmd.rev_start <= code_hit(sel, term_f, `ITM_FN_REV) & shut_enable;
      ctrl_cmd.second_function <= (~soc_on & f_second) |
        (drive_running & f_vf & ~vf_request);
      ctrl_cmd.stop_contact0 <= soc_on & f_low;
      ctrl_cmd.stop_contact1 <= soc_on & f_second;
      ctrl_cmd.analog_sel <= f_analog;
      ctrl_cmd.thermal_trip <= f_thermal;
      ctrl_cmd.run_enable <=
        code_hit(sel, '1, `ITM_FN_RUN_EN) ? f_run_en : shut_enable;
      ctrl_cmd.panel_interlock <=
        (!code_hit(sel, '1, `ITM_FN_INTERLOCK) &&
         operation_mode_selection == `ITM_OPMODE_INTERLOCK) ?
        ~shut_enable : f_interlock;
      ctrl_cmd.brake_open_done <= code_hit(sel, term_f, `ITM_FN_BRAKE);
      ctrl_cmd.panel_ext_sw <= code_hit(sel, term_f, `ITM_FN_PANEL_EXT);
      ctrl_cmd.vf_control <= vf_request;
      ctrl_cmd.panel_net_sw <= code_hit(sel, term_f, `ITM_FN_PANEL_NET);
      ctrl_cmd.ext_net_sw <= code_hit(sel, term_f, `ITM_FN_EXT_NET);
      ctrl_cmd.cmd_src_sw <= code_hit(sel, term_f, `ITM_FN_CMD_SRC);
      ctrl_cmd.self_hold <= code_hit(sel, term_f, `ITM_FN_SELF_HOLD);
      ctrl_cmd.drive_reset <= code_hit(sel, term_f, `ITM_FN_RESET);
    end
  end

  // ==========================================================
  // output shutoff
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      output_cut <= 1'b1;
      start_inhibit <= 1'b1;
    end
    else if (clk_en)
    begin
      // no mode gating: terminal shutoff acts in every mode
      // mode independent
      output_cut <= ~shut_enable;
      start_inhibit <= ~shut_enable;
    end
  end

  // ==========================================================
  // register read
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      bus_rdata <= '0;
    else if (clk_en)
    begin
      bus_rdata <= '0;
      if (bus_rd)
      begin
        for (int i = 0; i < NUM_TERM; i++)
        begin
          if (bus_addr == 8'(`ITM_OFS_SEL0 + i * `ITM_SEL_STRIDE))
            bus_rdata <= 32'(sel[i]);
        end
        unique case (bus_addr)
          `ITM_OFS_SHUTOFF:
            bus_rdata <= 32'(shutoff_input_logic_select);
          `ITM_OFS_REMOTE:
            bus_rdata <= 32'(remote_function_select);
          `ITM_OFS_SOC:
            bus_rdata <= 32'(stop_on_contact_select);
          `ITM_OFS_OPMODE:
            bus_rdata <= 32'(operation_mode_selection);
          `ITM_OFS_STATUS:
            bus_rdata <= 32'({ctrl_cmd, speed_cmd, remote_cmd, output_cut});
          `ITM_OFS_TERM:
            bus_rdata <= 32'(term_f);
          default:
            ;
        endcase
      end
    end
  end

endmodule

// ===== itm_mapper_assertions.sv
// Purpose: port-level checks of the input terminal function mapper
// Assumes: single mclk domain, reset active high
// Notes: bound onto every itm_mapper instance
`timescale 1ns/1ps

module itm_mapper_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // inputs watched
  input wire logic bus_rd,
  input wire logic drive_running,
  // outputs watched
  input wire logic [31:0] bus_rdata,
  input wire itm_pkg::itm_speed_s speed_cmd,
  input wire itm_pkg::itm_remote_s remote_cmd,
  input wire itm_pkg::itm_ctrl_s ctrl_cmd,
  input wire logic output_cut,
  input wire logic start_inhibit,
  input wire logic voltage_input_ignore
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // assertions
  a_inhibit_tracks_cut: assert property (
    start_inhibit == output_cut) else $error("start inhibit differs");
  a_start_gated: assert property (
    output_cut |-> !ctrl_cmd.fwd_start && !ctrl_cmd.rev_start)
    else $error("start passed while cut");
  a_jog_first: assert property (
    speed_cmd.jog |-> !(speed_cmd.low || speed_cmd.mid || speed_cmd.high
      || speed_cmd.ext || speed_cmd.pid_valid))
    else $error("speed beside jog");
  a_pid_last: assert property (
    (speed_cmd.low || speed_cmd.mid || speed_cmd.high || speed_cmd.ext)
      |-> !speed_cmd.pid_valid) else $error("pid beside multi speed");
  a_remote_excl: assert property (
    (remote_cmd != 3'b000) |-> !(speed_cmd.low || speed_cmd.mid
      || speed_cmd.high)) else $error("remote and speed together");
  a_contact_excl: assert property (
    ctrl_cmd.stop_contact0 |-> !speed_cmd.low && !remote_cmd.clear)
    else $error("stop contact shares input");
  a_read_idle: assert property (
    clk_en && !bus_rd |=> bus_rdata == 32'h0) else $error("stray read data");
  a_vf_stopped: assert property (
    $changed(ctrl_cmd.vf_control) |-> !$past(drive_running))
    else $error("method changed while running");
  a_analog_ignore: assert property (
    voltage_input_ignore == ctrl_cmd.analog_sel)
    else $error("voltage ignore differs");

  // ==========================================================
  // covers
  c_jog: cover property (speed_cmd.jog);
  c_cut_released: cover property ($fell(output_cut));
  c_remote_decel: cover property (remote_cmd.decel);
  c_vf_rise: cover property ($rose(ctrl_cmd.vf_control));
endmodule

bind itm_mapper itm_mapper_chk u_chk (.mclk(mclk), .rst(rst),
  .clk_en(clk_en), .bus_rd(bus_rd), .drive_running(drive_running),
  .bus_rdata(bus_rdata), .speed_cmd(speed_cmd), .remote_cmd(remote_cmd),
  .ctrl_cmd(ctrl_cmd), .output_cut(output_cut),
  .start_inhibit(start_inhibit),
  .voltage_input_ignore(voltage_input_ignore));

// ===== itm_pkg.sv
// Purpose: carrier types of the input terminal function mapper
// Assumes: codes and offsets live in itm_map.svh
// Notes: packed structs only
package itm_pkg;

  // ==========================================================
  // speed command after priority
  typedef struct packed {
    logic jog;
    logic low;
    logic mid;
    logic high;
    logic ext;
    logic pid_valid;
  } itm_speed_s;

  // ==========================================================
  // remote setting commands
  typedef struct packed {
    logic clear;
    logic decel;
    logic accel;
  } itm_remote_s;

  // ==========================================================
  // other internal commands
  typedef struct packed {
    logic fwd_start;
    logic rev_start;
    logic second_function;
    logic stop_contact0;
    logic stop_contact1;
    logic analog_sel;
    logic thermal_trip;
    logic run_enable;
    logic panel_interlock;
    logic brake_open_done;
    logic panel_ext_sw;
    logic vf_control;
    logic panel_net_sw;
    logic ext_net_sw;
    logic cmd_src_sw;
    logic self_hold;
    logic drive_reset;
  } itm_ctrl_s;

endpackage

// ===== tb_top.sv
// Purpose: self-checking bench of the input terminal function mapper
// Assumes: short filter counts 4 and 8, clk_en dropped once to freeze
// Notes: random terminal patterns from a fixed seed
`timescale 1ns/1ps
`include "itm_map.svh"

module tb_top;
  localparam int FAST = 4;
  localparam int SLOW = 8;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic [6:0] want = 7'h00;
  logic [6:0] glitch = 7'h00;
  logic [6:0] term_in;
  logic comm = 1'b0;
  logic running = 1'b0;
  logic ce = 1'b1;
  itm_pkg::itm_speed_s speed_cmd;
  itm_pkg::itm_remote_s remote_cmd;
  itm_pkg::itm_ctrl_s ctrl_cmd;
  logic output_cut;
  logic start_inhibit;
  logic vin_ign;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  integer seed = 32'h250e;
  logic [15:0] dflt [7] = '{16'h003C, 16'h003D, 16'h0000, 16'h0001,
    16'h0002, 16'h0018, 16'h003E};
  logic [15:0] fcode [11] = '{16'h0010, 16'h0041, 16'h0042, 16'h0043,
    16'h000F, 16'h000A, 16'h000C, 16'h0019, 16'h003E, 16'h0003, 16'h0004};
  int fbit [11] = '{6, 4, 3, 2, 7, 9, 8, 1, 0, 14, 11};
  int lg [3] = '{0, 2, 4};

  always #10 mclk = ~mclk;

  itm_mapper #(.NUM_TERM(7), .FAST_FILT_CYC(FAST), .SLOW_FILT_CYC(SLOW)) DUT (
    .mclk(mclk), .rst(rst), .clk_en(ce), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .term_in(term_in), .comm_shutoff_in(comm),
    .drive_running(running), .speed_cmd(speed_cmd),
    .remote_cmd(remote_cmd), .ctrl_cmd(ctrl_cmd), .output_cut(output_cut),
    .start_inhibit(start_inhibit), .voltage_input_ignore(vin_ign));

  itm_contacts u_contacts (.mclk(mclk), .want(want), .glitch(glitch),
    .term_in(term_in));

  // ==========================================================
  // helpers
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= {16'h0000, d};
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, {16'h0000, e});
  endtask

  task automatic sel(input int i, input logic [15:0] c);
    wr(8'(`ITM_OFS_SEL0 + `ITM_SEL_STRIDE * i), c);
  endtask

  task automatic settle;
    repeat (SLOW + 8) @(posedge mclk);
    #1;
  endtask

  task automatic term(input logic [6:0] v, input logic c);
    @(posedge mclk);
    want <= v;
    comm <= c;
    settle();
  endtask

  function automatic logic en(input int l, input logic t, input logic c);
    case (l)
      0: en = !t && !c;
      2: en = t && c;
      default: en = t && !c;
    endcase
  endfunction

  function automatic logic [8:0] exp_spd(input logic [6:0] f,
    input logic rem, input logic soc);
    logic jog;
    logic lo;
    logic md;
    logic hi;
    logic ex;
    jog = f[6];
    lo = !jog && !rem && !soc && f[2];
    md = !jog && !rem && f[3];
    hi = !jog && !rem && f[1];
    ex = !jog && f[4];
    exp_spd = {jog, lo, md, hi, ex, f[5] && !jog && !(lo || md || hi || ex),
      rem && !soc && f[2], rem && f[3], rem && f[1]};
  endfunction

  // ==========================================================
  // hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic rem;
    logic e;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rdchk(8'(`ITM_OFS_SEL0 + `ITM_SEL_STRIDE * i), dflt[i]);
    rdchk(`ITM_OFS_SHUTOFF, 16'h0000);
    rdchk(8'h34, 16'h0000);
    sel(2, 16'h003C);
    sel(0, 16'h003D);
    sel(3, 16'h0006);
    sel(4, 16'h2710);
    wr(`ITM_OFS_SHUTOFF, 16'h0003);
    rdchk(8'h08, 16'h0000);
    rdchk(8'h00, 16'h003C);
    rdchk(8'h0C, 16'h0001);
    rdchk(8'h10, 16'h0002);
    rdchk(`ITM_OFS_SHUTOFF, 16'h0000);
    foreach (lg[j])
    begin
      wr(`ITM_OFS_SHUTOFF, 16'(lg[j]));
      for (int k = 0; k < 4; k++)
      begin
        term({1'b0, k[1], 4'h0, 1'b1}, k[0]);
        e = en(lg[j], k[1], k[0]);
        chk(output_cut, !e);
        chk(start_inhibit, !e);
        chk(ctrl_cmd.fwd_start, e);
      end
    end
    wr(`ITM_OFS_SHUTOFF, 16'h0000);
    wr(`ITM_OFS_OPMODE, 16'h0002);
    term(7'h00, 1'b0);
    @(posedge mclk);
    running <= 1'b1;
    want <= 7'h20;
    repeat (FAST + 7) @(posedge mclk);
    #1 chk(output_cut, 1'b1);
    term(7'h00, 1'b0);
    @(posedge mclk);
    glitch <= 7'h20;
    repeat (2) @(posedge mclk);
    glitch <= 7'h00;
    settle();
    chk(output_cut, 1'b0);
    // clock enable low must freeze the synchronisers and outputs
    @(posedge mclk);
    ce <= 1'b0;
    want <= 7'h20;
    settle();
    chk(output_cut, 1'b0);
    @(posedge mclk);
    ce <= 1'b1;
    wr(`ITM_OFS_OPMODE, 16'h0007);
    term(7'h20, 1'b0);
    chk(ctrl_cmd.run_enable, 1'b0);
    chk(ctrl_cmd.panel_interlock, 1'b1);
    wr(`ITM_OFS_OPMODE, 16'h0000);
    settle();
    chk(ctrl_cmd.panel_interlock, 1'b0);
    term(7'h00, 1'b0);
    chk(ctrl_cmd.run_enable, 1'b1);
    foreach (fcode[n])
    begin
      sel(6, fcode[n]);
      term(7'h40, 1'b0);
      chk(ctrl_cmd[fbit[n]], 1'b1);
    end
    chk(vin_ign, 1'b1);
    sel(6, 16'h270F);
    settle();
    chk(ctrl_cmd, 32'h00000200);
    sel(4, 16'h0007);
    term(7'h10, 1'b0);
    chk(ctrl_cmd.thermal_trip, 1'b0);
    term(7'h00, 1'b0);
    chk(ctrl_cmd.thermal_trip, 1'b1);
    sel(4, 16'h0012);
    term(7'h10, 1'b0);
    chk(ctrl_cmd.vf_control, 1'b0);
    chk(ctrl_cmd.second_function, 1'b1);
    @(posedge mclk);
    running <= 1'b0;
    settle();
    chk(ctrl_cmd.vf_control, 1'b1);
    @(posedge mclk);
    running <= 1'b1;
    term(7'h00, 1'b0);
    chk(ctrl_cmd.vf_control, 1'b1);
    @(posedge mclk);
    running <= 1'b0;
    settle();
    chk(ctrl_cmd.vf_control, 1'b0);
    sel(4, 16'h0000);
    term(7'h10, 1'b0);
    chk(speed_cmd.low, 1'b1);
    sel(1, 16'h0002);
    sel(3, 16'h0001);
    sel(4, 16'h0008);
    sel(5, 16'h000E);
    sel(6, 16'h0005);
    for (int n = 0; n < 40; n++)
    begin
      r = (n == 0) ? 32'h0000007F : $random(seed);
      rem = r[9] | r[8];
      wr(`ITM_OFS_REMOTE, {14'h0000, r[9], r[8] & ~r[9]});
      wr(`ITM_OFS_SOC, {15'h0000, r[10]});
      term(r[6:0], 1'b0);
      chk({speed_cmd, remote_cmd}, exp_spd(r[6:0], rem, r[10]));
      chk(ctrl_cmd.stop_contact0, r[10] & r[2]);
      chk(ctrl_cmd.fwd_start, r[0]);
    end
    wr(`ITM_OFS_SOC, 16'h0001);
    sel(5, 16'h0003);
    term(7'h20, 1'b0);
    chk(ctrl_cmd.stop_contact1, 1'b1);
    chk(ctrl_cmd.second_function, 1'b0);
    rdchk(`ITM_OFS_TERM, 16'h0020);
    print_verdict();
  end
endmodule
